// File: timer_consts.vh
// Register offsets, field positions, reset values and timing counts of the reload timers.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define OFS_T0_CNT_LO   8'h0c
`define OFS_T0_CNT_HI   8'h0d
`define OFS_T0_RLD_LO   8'h0e
`define OFS_T0_RLD_HI   8'h0f
`define OFS_TCTRL       8'h10
`define OFS_T1_CNT_LO   8'h14
`define OFS_T1_CNT_HI   8'h15
`define OFS_T1_RLD_LO   8'h16
`define OFS_T1_RLD_HI   8'h17
`define OFS_FREE        8'h18
`define BIT_ZF1         7
`define BIT_ZF0         6
`define BIT_IE1         5
`define BIT_IE0         4
`define BIT_OC_HI       3
`define BIT_OC_LO       2
`define BIT_CE1         1
`define BIT_CE0         0
`define OC_KEEP         2'b00
`define OC_TOGGLE       2'b01
`define OC_LOW          2'b10
`define OC_HIGH         2'b11
`define FREE_RST        8'hff
`define CHAN_RST        16'hffff
`define TIMER_DIV       20
`define FREE_DIV        10
`endif

// File: reload_channel.v
// One 16-bit down-counting channel with a 16-bit reload value.
`timescale 1ns/100ps
module reload_channel (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        tick,
  input  wire        count_en,
  input  wire [7:0]  wdata,
  input  wire        wr_cnt_lo,
  input  wire        wr_cnt_hi,
  input  wire        wr_rld_lo,
  input  wire        wr_rld_hi,
  output wire [15:0] count_value,
  output wire [15:0] reload_value,
  output wire        zero_hit
);
`include "timer_consts.vh"

  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg [15:0] rld_r;

  assign count_value  = cnt_r;
  assign reload_value = rld_r;
  // One-cycle pulse on the decrement that lands on zero.
  assign zero_hit     = tick && count_en && (cnt_r == 16'h0001) && !wr_cnt_lo && !wr_cnt_hi;

  always @* begin
    cnt_nxt = cnt_r;
    if (tick && count_en) begin
      if (cnt_r == 16'h0000) begin
        cnt_nxt = rld_r;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
    // A software byte write overrides the count in the same cycle.
    if (wr_cnt_lo) begin
      cnt_nxt = {cnt_r[15:8], wdata};
    end
    if (wr_cnt_hi) begin
      cnt_nxt = {wdata, cnt_r[7:0]};
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= `CHAN_RST;
      rld_r <= `CHAN_RST;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      if (wr_rld_lo) begin
        rld_r[7:0] <= wdata;
      end
      if (wr_rld_hi) begin
        rld_r[15:8] <= wdata;
      end
    end
  end
endmodule // reload_channel

// File: dual_reload_timer.v
// Two reload timer channels, shared control register and free-running counter.
// Functional notes
// - A channel reaching zero sets its zero flag: channel 1 bit 7, channel 0 bit 6.
// - A zero flag clears after a control read followed by a counter byte read.
// - Reset forces both zero flags to zero.
// - Interrupt request when a zero flag and its enable are both set; enables reset low.
// - Channel 1 zero applies output field: keep, toggle, drive low, drive high.
// - Output field acts on the pin only while the DMA top-byte bit 3 selects it.
// - Reset clears the output field so the pin is left alone.
// - Counters decrement only while their enable is set; reset clears both enables.
// - Software reads and writes counter bytes freely while counting is stopped.
// - The free-running counter is loaded with all ones at reset.
// - The free-running counter keeps counting during peripheral stop mode.
`timescale 1ns/100ps
`include "timer_consts.vh"
module dual_reload_timer #(
  parameter TIMER_DIV = `TIMER_DIV,
  parameter FREE_DIV  = `FREE_DIV
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       ce,
  input  wire [7:0] io_addr,
  input  wire [7:0] io_wdata,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire       dma1_io_addr_top_byte_b3,
  input  wire       peripheral_stop_mode,
  output reg  [7:0] io_rdata_r,
  output reg        irq_r,
  output reg        timer_out_or_dma_req_pin_r,
  output reg        timer_out_sel_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers.

  reg  [7:0]  tdiv_r;
  reg  [7:0]  fdiv_r;
  reg  [7:0]  free_counter_r;
  wire        timer_tick;
  wire        free_tick;

  // Timers halt in peripheral stop mode; the free counter does not.
  assign timer_tick = (tdiv_r == 8'h00) && !peripheral_stop_mode;
  assign free_tick  = (fdiv_r == 8'h00);

  always @(posedge clk) begin
    if (!rst_b) begin
      tdiv_r         <= 8'h00;
      fdiv_r         <= 8'h00;
      free_counter_r <= `FREE_RST;
    end else if (ce) begin
      if (!peripheral_stop_mode) begin
        tdiv_r <= (tdiv_r == 8'h00) ? TIMER_DIV[7:0] - 8'h01 : tdiv_r - 8'h01;
      end
      fdiv_r <= (fdiv_r == 8'h00) ? FREE_DIV[7:0] - 8'h01 : fdiv_r - 8'h01;
      // A write is honoured but upsets everything timed from this counter.
      if (io_wr && io_addr == `OFS_FREE) begin
        free_counter_r <= io_wdata;
      end else if (free_tick) begin
        free_counter_r <= free_counter_r - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire w_c0l = io_wr && hit(io_addr, `OFS_T0_CNT_LO);
  wire w_c0h = io_wr && hit(io_addr, `OFS_T0_CNT_HI);
  wire w_r0l = io_wr && hit(io_addr, `OFS_T0_RLD_LO);
  wire w_r0h = io_wr && hit(io_addr, `OFS_T0_RLD_HI);
  wire w_c1l = io_wr && hit(io_addr, `OFS_T1_CNT_LO);
  wire w_c1h = io_wr && hit(io_addr, `OFS_T1_CNT_HI);
  wire w_r1l = io_wr && hit(io_addr, `OFS_T1_RLD_LO);
  wire w_r1h = io_wr && hit(io_addr, `OFS_T1_RLD_HI);
  wire w_tc  = io_wr && hit(io_addr, `OFS_TCTRL);
  wire r_tc  = io_rd && hit(io_addr, `OFS_TCTRL);
  wire r_c0  = io_rd && (hit(io_addr, `OFS_T0_CNT_LO) || hit(io_addr, `OFS_T0_CNT_HI));
  wire r_c1  = io_rd && (hit(io_addr, `OFS_T1_CNT_LO) || hit(io_addr, `OFS_T1_CNT_HI));

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  reg         ie1_r;
  reg         ie0_r;
  reg  [1:0]  oc_r;
  reg         ce1_r;
  reg         ce0_r;
  reg         zf1_r;
  reg         zf0_r;
  reg         arm1_r;
  reg         arm0_r;
  wire [15:0] cnt0;
  wire [15:0] rld0;
  wire [15:0] cnt1;
  wire [15:0] rld1;
  wire        zero0;
  wire        zero1;

  reload_channel u_chan0 (
    .clk          (clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .tick         (timer_tick),
    .count_en     (ce0_r),
    .wdata        (io_wdata),
    .wr_cnt_lo    (w_c0l),
    .wr_cnt_hi    (w_c0h),
    .wr_rld_lo    (w_r0l),
    .wr_rld_hi    (w_r0h),
    .count_value  (cnt0),
    .reload_value (rld0),
    .zero_hit     (zero0)
  );

  reload_channel u_chan1 (
    .clk          (clk),
    .rst_b        (rst_b),
    .ce           (ce),
    .tick         (timer_tick),
    .count_en     (ce1_r),
    .wdata        (io_wdata),
    .wr_cnt_lo    (w_c1l),
    .wr_cnt_hi    (w_c1h),
    .wr_rld_lo    (w_r1l),
    .wr_rld_hi    (w_r1h),
    .count_value  (cnt1),
    .reload_value (rld1),
    .zero_hit     (zero1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register, zero flags and the clear sequence.

  wire [7:0] tctrl = {zf1_r, zf0_r, ie1_r, ie0_r, oc_r, ce1_r, ce0_r};

  always @(posedge clk) begin
    if (!rst_b) begin
      ie1_r  <= 1'b0;
      ie0_r  <= 1'b0;
      oc_r   <= `OC_KEEP;
      ce1_r  <= 1'b0;
      ce0_r  <= 1'b0;
      zf1_r  <= 1'b0;
      zf0_r  <= 1'b0;
      arm1_r <= 1'b0;
      arm0_r <= 1'b0;
    end else if (ce) begin
      if (w_tc) begin
        ie1_r <= io_wdata[`BIT_IE1];
        ie0_r <= io_wdata[`BIT_IE0];
        oc_r  <= io_wdata[`BIT_OC_HI:`BIT_OC_LO];
        ce1_r <= io_wdata[`BIT_CE1];
        ce0_r <= io_wdata[`BIT_CE0];
      end
      // A control read arms the clear only for a flag that it saw set.
      if (r_tc) begin
        arm1_r <= zf1_r;
        arm0_r <= zf0_r;
      end else begin
        if (r_c1) arm1_r <= 1'b0;
        if (r_c0) arm0_r <= 1'b0;
      end
      // Hardware set wins over the software clear in the same cycle.
      if (zero1) begin
        zf1_r <= 1'b1;
      end else if (r_c1 && arm1_r) begin
        zf1_r <= 1'b0;
      end
      if (zero0) begin
        zf0_r <= 1'b1;
      end else if (r_c0 && arm0_r) begin
        zf0_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, output pin and read data.

  reg [7:0] rdata_nxt;

  always @* begin
    case (io_addr)
      `OFS_T0_CNT_LO: rdata_nxt = cnt0[7:0];
      `OFS_T0_CNT_HI: rdata_nxt = cnt0[15:8];
      `OFS_T0_RLD_LO: rdata_nxt = rld0[7:0];
      `OFS_T0_RLD_HI: rdata_nxt = rld0[15:8];
      `OFS_TCTRL:     rdata_nxt = tctrl;
      `OFS_T1_CNT_LO: rdata_nxt = cnt1[7:0];
      `OFS_T1_CNT_HI: rdata_nxt = cnt1[15:8];
      `OFS_T1_RLD_LO: rdata_nxt = rld1[7:0];
      `OFS_T1_RLD_HI: rdata_nxt = rld1[15:8];
      `OFS_FREE:      rdata_nxt = free_counter_r;
      default:        rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      io_rdata_r                 <= 8'h00;
      irq_r                      <= 1'b0;
      timer_out_or_dma_req_pin_r <= 1'b0;
      timer_out_sel_r            <= 1'b0;
    end else if (ce) begin
      if (io_rd) begin
        io_rdata_r <= rdata_nxt;
      end
      irq_r           <= (zf1_r && ie1_r) || (zf0_r && ie0_r);
      timer_out_sel_r <= dma1_io_addr_top_byte_b3;
      // The pin level is only touched while the timer function owns it.
      if (zero1 && dma1_io_addr_top_byte_b3) begin
        case (oc_r)
          `OC_TOGGLE: timer_out_or_dma_req_pin_r <= !timer_out_or_dma_req_pin_r;
          `OC_LOW:    timer_out_or_dma_req_pin_r <= 1'b0;
          `OC_HIGH:   timer_out_or_dma_req_pin_r <= 1'b1;
          default:    timer_out_or_dma_req_pin_r <= timer_out_or_dma_req_pin_r;
        endcase
      end
    end
  end
endmodule // dual_reload_timer

// File: dual_reload_timer_assertions.sv
// Port-level assertions for the dual reload timer.
`timescale 1ns/100ps
module timer_checker #(
  parameter TIMER_DIV = 20,
  parameter FREE_DIV  = 10
) (
  input wire       clk,
  input wire       rst_b,
  input wire       ce,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire       io_wr,
  input wire       io_rd,
  input wire       dma1_io_addr_top_byte_b3,
  input wire       peripheral_stop_mode,
  input wire [7:0] io_rdata_r,
  input wire       irq_r,
  input wire       timer_out_or_dma_req_pin_r,
  input wire       timer_out_sel_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Helper terms keep every sampled-value call on a plain signal.
  wire       acc_any = ce && (io_rd || io_wr);
  wire [5:0] wd_low  = io_wdata[5:0];
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_ctrl;
    ce && io_wr && io_addr == 8'h10;
  endsequence
  sequence s_rd_ctrl;
    ce && io_rd && io_addr == 8'h10;
  endsequence
  // The reset check cannot be disabled by the reset it watches.
  property p_rst;
    disable iff (1'b0) (!rst_b && ce) |=> io_rdata_r == 8'h00 && !irq_r && !timer_out_or_dma_req_pin_r;
  endproperty
  property p_sel;
    (ce && rst_b) |=> timer_out_sel_r == $past(dma1_io_addr_top_byte_b3);
  endproperty
  // A pin drop caused by reset is not a timer action.
  property p_pin_gate;
    ($changed(timer_out_or_dma_req_pin_r) && $past(rst_b)) |-> $past(dma1_io_addr_top_byte_b3);
  endproperty
  property p_freeze;
    (!ce && rst_b) |=> $stable(io_rdata_r) && $stable(irq_r) && $stable(timer_out_or_dma_req_pin_r);
  endproperty
  property p_irq_fall;
    ($fell(irq_r) && $past(rst_b)) |-> $past(acc_any, 2) || $past(acc_any);
  endproperty
  property p_unmapped;
    (ce && io_rd && io_addr == 8'h11) |=> io_rdata_r == 8'h00;
  endproperty
  property p_hold;
    (rst_b && !(ce && io_rd)) |=> $stable(io_rdata_r);
  endproperty
  property p_ctrl_rw;
    s_wr_ctrl ##2 s_rd_ctrl |=> io_rdata_r[5:0] == $past(wd_low, 3);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_sel: assert property (p_sel) else $error("pin select copy wrong");
  a_pin_gate: assert property (p_pin_gate) else $error("pin moved while not selected");
  a_freeze: assert property (p_freeze) else $error("outputs moved while ce low");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_ctrl_rw: assert property (p_ctrl_rw) else $error("control bits not written");
endmodule // timer_checker
bind dual_reload_timer timer_checker #(.TIMER_DIV(TIMER_DIV), .FREE_DIV(FREE_DIV)) u_chk (.*);

// File: tb.sv
// Self-checking bench for the dual reload timer.
`timescale 1ns/100ps
module tb;
  localparam [39:0] MODES = 40'h0e0a06020a;
  localparam [4:0]  PINS  = 5'b11101;
  localparam [4:0]  SELS  = 5'b01111;
  reg        clk;
  reg        rst_b;
  reg        ce;
  reg  [7:0] io_addr;
  reg  [7:0] io_wdata;
  reg        io_wr;
  reg        io_rd;
  reg        sel;
  reg        stop;
  wire [7:0] io_rdata_r;
  wire       irq_r;
  wire       pin_r;
  wire       sel_r;
  integer    errors;
  integer    n_compared;
  integer    cyc;
  integer    i;
  reg  [7:0] v;
  reg  [7:0] w;
  // Short dividers keep every wait in the run to a few tens of cycles.
  dual_reload_timer #(.TIMER_DIV(2), .FREE_DIV(2)) dut (
    .clk                        (clk),
    .rst_b                      (rst_b),
    .ce                         (ce),
    .io_addr                    (io_addr),
    .io_wdata                   (io_wdata),
    .io_wr                      (io_wr),
    .io_rd                      (io_rd),
    .dma1_io_addr_top_byte_b3   (sel),
    .peripheral_stop_mode       (stop),
    .io_rdata_r                 (io_rdata_r),
    .irq_r                      (irq_r),
    .timer_out_or_dma_req_pin_r (pin_r),
    .timer_out_sel_r            (sel_r)
  );
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] name, input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1 d = io_rdata_r;
    end
  endtask
  task report_and_stop;
    begin
      if (errors == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  // The free counter is only ever read here, never written.
  initial begin
    {rst_b, io_addr, io_wdata, io_wr, io_rd, sel, stop, errors, n_compared, cyc} = 0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h18, v);
    chk("free", {7'h0, v >= 8'hfd}, 8'h01);
    rd(8'h10, v);
    chk("ctrl", v, 8'h00);
    rd(8'h0c, v);
    chk("cnt0", v, 8'hff);
    wr(8'h0c, 8'h02);
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'h03);
    wr(8'h0f, 8'h00);
    rd(8'h0e, v);
    chk("rld0", v, 8'h03);
    rd(8'h0c, v);
    chk("cnt0", v, 8'h02);
    wr(8'h10, 8'h11);
    repeat (20) @(posedge clk);
    wr(8'h10, 8'h10);
    // A count read without a prior control read must leave the flag set.
    rd(8'h0d, v);
    chk("cnt0h", v, 8'h00);
    rd(8'h10, v);
    chk("ctrl", v, 8'h50);
    chk("irq", {7'h0, irq_r}, 8'h01);
    rd(8'h0c, v);
    chk("cnt0", {7'h0, v <= 8'h03}, 8'h01);
    rd(8'h10, v);
    chk("ctrl", v, 8'h10);
    chk("irq", {7'h0, irq_r}, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      sel <= SELS[i];
      wr(8'h14, 8'h01);
      wr(8'h15, 8'h00);
      wr(8'h10, MODES[39 - 8 * i -: 8]);
      repeat (10) @(posedge clk);
      wr(8'h10, 8'h00);
      #1 chk("pin", {7'h0, pin_r}, {7'h0, PINS[i]});
      chk("sel", {7'h0, sel_r}, {7'h0, SELS[i]});
      rd(8'h10, v);
      chk("ctrl", v, 8'h80);
      // Clearing the flag here makes the next pass prove a fresh zero.
      rd(8'h14, w);
    end
    stop <= 1'b1;
    rd(8'h18, v);
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    rd(8'h18, w);
    chk("free", {7'h0, v != w}, 8'h01);
    wr(8'h11, 8'h5a);
    rd(8'h11, v);
    chk("unmapped", v, 8'h00);
    wr(8'h10, 8'h3d);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h10, v);
    chk("ctrl", v, 8'h00);
    chk("pin", {7'h0, pin_r}, 8'h00);
    report_and_stop;
  end
endmodule // tb
